// ---- inc/dma_ch3_params.svh ----
// Purpose: Offsets, field positions and codes of the channel 3 block
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef DMA_CH3_PARAMS_SVH
`define DMA_CH3_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define OFF_CONFIG 8'h30
`define OFF_COUNT 8'h34
`define OFF_PERIPH 8'h38
`define OFF_MEMORY 8'h3c

// ==========================================================
// Configuration field positions
`define CFG_WIDTH 15
`define CFG_EN_BIT 0
`define CFG_CYCLIC_BIT 5
`define CFG_PWIDTH_LO 8
`define CFG_MWIDTH_LO 10

// ==========================================================
// Width codes
`define WIDTH_BYTE 2'b00
`define WIDTH_HALF 2'b01
`define WIDTH_WORD 2'b10

// ==========================================================
// Reset values
`define RST_CONFIG 15'h0000
`define RST_COUNT 16'h0000
`define RST_ADDR 32'h0000_0000

`endif

// ---- inc/dma_ch3_pkg.sv ----
// Purpose: Types shared by the channel 3 block
// Assumes: Nothing
// Notes: State record and transfer descriptor
package dma_ch3_pkg;

   typedef struct packed {
      logic [31:0] paddr;
      logic [31:0] maddr;
      logic [1:0] pwidth;
      logic [1:0] mwidth;
   } xfer_type;

   typedef struct packed {
      logic [14:0] cfg;
      logic [15:0] count;
      logic [15:0] prog;
      logic [31:0] paddr;
      logic [31:0] maddr;
      logic [15:0] pending;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic out_valid;
      xfer_type out_data;
      logic skid_valid;
      xfer_type skid_data;
   } state_type;

endpackage

// ---- logic/dma_channel_count_address.sv ----
// Purpose: Count and address part of DMA channel 3 behind APB
// Assumes: Bus engine pulses xfer_done once per finished transfer
// Notes: Descriptors leave through a two-entry buffer
//
// Behaviour
// - Count writes are dropped while the channel is enabled.
// - Enabled channel: count is read-only and reads remaining transfers.
// - Count drops by one after each finished transfer.
// - Without cyclic mode the count ends at zero.
// - With cyclic mode the count reloads the last programmed value.
// - A zero count issues no transfer even when enabled.
// - Count is sixteen bits in the low half; upper half reads zero.
// - Peripheral address register holds a 32-bit data register address.
// - Halfword peripheral width clears peripheral address bit 0.
// - Word peripheral width clears peripheral address bits 1 and 0.
// - Memory address register holds a 32-bit memory address.
// - Halfword memory width clears memory address bit 0.
// - Word memory width clears memory address bits 1 and 0.
// - Peripheral width codes 00, 01, 10 give 8, 16, 32 bits.
// - Memory width codes 00, 01, 10 give 8, 16, 32 bits.
// - Configuration bit set to 1 turns cyclic mode on.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "dma_ch3_params.svh"

module dma_channel_count_address (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic xfer_valid,
   input wire logic xfer_ready,
   output dma_ch3_pkg::xfer_type xfer_desc,
   input wire logic xfer_done,
   output logic [15:0] remaining
);

   // ==========================================================
   // Reset release
   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign rst_n = rst_sync_q;

   // ==========================================================
   // Helpers
   function automatic logic [1:0] width_code(input logic [1:0] code);
      logic [1:0] w;
      w = `WIDTH_BYTE;
      // Reserved code falls back to byte accesses
      if (code == `WIDTH_HALF) begin
         w = `WIDTH_HALF;
      end else if (code == `WIDTH_WORD) begin
         w = `WIDTH_WORD;
      end
      return w;
   endfunction

   function automatic logic [31:0] align(input logic [31:0] a,
                                         input logic [1:0] w);
      logic [31:0] r;
      r = a;
      if (w == `WIDTH_HALF) begin
         r[0] = 1'b0;
      end else if (w == `WIDTH_WORD) begin
         r[1:0] = 2'b00;
      end
      return r;
   endfunction

   // ==========================================================
   // State
   dma_ch3_pkg::state_type q;
   dma_ch3_pkg::state_type d;

   logic enabled;
   logic cyclic;
   logic [1:0] pw;
   logic [1:0] mw;
   logic access;
   logic in_ready;
   logic push;
   logic finish;
   dma_ch3_pkg::xfer_type fresh;

   assign enabled = q.cfg[`CFG_EN_BIT];
   assign cyclic = q.cfg[`CFG_CYCLIC_BIT];
   assign pw = width_code(q.cfg[`CFG_PWIDTH_LO +: 2]);
   assign mw = width_code(q.cfg[`CFG_MWIDTH_LO +: 2]);
   assign access = psel & penable;
   assign in_ready = ~q.skid_valid;
   // Only ask for transfers not yet covered by outstanding ones
   assign push = enabled & (q.count > q.pending) & in_ready;
   assign finish = xfer_done & (q.count != 16'h0000);

   always_comb begin
      fresh.paddr = align(q.paddr, pw);
      fresh.maddr = align(q.maddr, mw);
      fresh.pwidth = pw;
      fresh.mwidth = mw;
   end

   // ==========================================================
   // Next state
   always_comb begin
      d = q;
      d.pready = access & ~q.pready;
      d.pslverr = 1'b0;

      // Read data and error set up in the first access cycle
      if (access && !q.pready) begin
         d.pslverr = 1'b0;
         d.prdata = 32'h0000_0000;
         if (paddr == `OFF_CONFIG) begin
            d.prdata[14:0] = q.cfg;
         end else if (paddr == `OFF_COUNT) begin
            d.prdata[15:0] = q.count;
         end else if (paddr == `OFF_PERIPH) begin
            d.prdata = q.paddr;
         end else if (paddr == `OFF_MEMORY) begin
            d.prdata = q.maddr;
         end else begin
            d.pslverr = 1'b1;
         end
      end

      // Count bookkeeping
      if (finish) begin
         if (q.count == 16'h0001) begin
            d.count = cyclic ? q.prog : 16'h0000;
         end else begin
            d.count = q.count - 16'h0001;
         end
      end
      if (push && !(xfer_done && q.pending != 16'h0000)) begin
         d.pending = q.pending + 16'h0001;
      end else if (!push && xfer_done && q.pending != 16'h0000) begin
         d.pending = q.pending - 16'h0001;
      end

      // Writes take effect at the edge that sees pready
      if (access && q.pready && pwrite && !q.pslverr) begin
         if (paddr == `OFF_CONFIG) begin
            if (pstrb[0]) begin
               d.cfg[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               d.cfg[14:8] = pwdata[14:8];
            end
         end else if (paddr == `OFF_COUNT) begin
            if (!enabled) begin
               if (pstrb[0]) begin
                  d.count[7:0] = pwdata[7:0];
                  d.prog[7:0] = pwdata[7:0];
               end
               if (pstrb[1]) begin
                  d.count[15:8] = pwdata[15:8];
                  d.prog[15:8] = pwdata[15:8];
               end
            end
         end else if (paddr == `OFF_PERIPH) begin
            for (int i = 0; i < 4; i++) begin
               if (pstrb[i]) begin
                  d.paddr[i*8 +: 8] = pwdata[i*8 +: 8];
               end
            end
         end else if (paddr == `OFF_MEMORY) begin
            for (int i = 0; i < 4; i++) begin
               if (pstrb[i]) begin
                  d.maddr[i*8 +: 8] = pwdata[i*8 +: 8];
               end
            end
         end
      end

      // Two-entry buffer toward the bus engine
      if (!q.out_valid || xfer_ready) begin
         if (q.skid_valid) begin
            d.out_valid = 1'b1;
            d.out_data = q.skid_data;
            d.skid_valid = 1'b0;
         end else begin
            d.out_valid = push;
            d.out_data = fresh;
         end
      end else if (push) begin
         d.skid_valid = 1'b1;
         d.skid_data = fresh;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.cfg <= `RST_CONFIG;
         q.count <= `RST_COUNT;
         q.prog <= `RST_COUNT;
         q.paddr <= `RST_ADDR;
         q.maddr <= `RST_ADDR;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign xfer_valid = q.out_valid;
   assign xfer_desc = q.out_data;
   assign remaining = q.count;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_count_write_locked: assert property (
      (access && q.pready && pwrite && paddr == `OFF_COUNT && enabled
       && !xfer_done) |=> $stable(q.count))
      else $error("count changed by a write while enabled");

   a_count_read_back: assert property (
      (access && !q.pready && !pwrite && paddr == `OFF_COUNT)
      |=> (prdata == {16'h0000, $past(q.count)}) && pready)
      else $error("count read returned wrong value");

   a_count_decrement: assert property (
      (xfer_done && q.count > 16'h0001 && !(access && q.pready))
      |=> q.count == $past(q.count) - 16'h0001)
      else $error("count did not drop by one");

   a_count_end_zero: assert property (
      (xfer_done && q.count == 16'h0001 && !cyclic)
      |=> q.count == 16'h0000)
      else $error("count did not end at zero");

   a_count_reload: assert property (
      (xfer_done && q.count == 16'h0001 && cyclic)
      |=> q.count == $past(q.prog))
      else $error("count not reloaded in cyclic mode");

   a_zero_no_push: assert property (
      (q.count == 16'h0000 && !q.skid_valid && !(q.out_valid && !xfer_ready))
      |=> !xfer_valid)
      else $error("transfer queued with zero count");

   a_periph_half_align: assert property (
      (xfer_valid && xfer_desc.pwidth == `WIDTH_HALF)
      |-> xfer_desc.paddr[0] == 1'b0)
      else $error("peripheral halfword address misaligned");

   a_periph_word_align: assert property (
      (xfer_valid && xfer_desc.pwidth == `WIDTH_WORD)
      |-> xfer_desc.paddr[1:0] == 2'b00)
      else $error("peripheral word address misaligned");

   a_mem_word_align: assert property (
      xfer_valid |-> (xfer_desc.mwidth != `WIDTH_HALF
                      || !xfer_desc.maddr[0])
                     && (xfer_desc.mwidth != `WIDTH_WORD
                      || xfer_desc.maddr[1:0] == 2'b00))
      else $error("memory address misaligned");

   a_width_legal: assert property (
      xfer_valid |-> xfer_desc.pwidth != 2'b11
                     && xfer_desc.mwidth != 2'b11)
      else $error("reserved width code issued");

   a_buffer_hold: assert property (
      (xfer_valid && !xfer_ready) |=> xfer_valid && $stable(xfer_desc))
      else $error("descriptor lost under stall");

   a_pready_pulse: assert property (
      pready |=> !pready)
      else $error("ready held longer than one cycle");

   a_pready_answer: assert property (
      (access && !q.pready) |=> pready)
      else $error("access not answered in one cycle");

   a_unmapped_error: assert property (
      (access && !q.pready && paddr != `OFF_CONFIG && paddr != `OFF_COUNT
       && paddr != `OFF_PERIPH && paddr != `OFF_MEMORY)
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   a_count_upper_zero: assert property (
      (access && !q.pready && paddr == `OFF_COUNT)
      |=> prdata[31:16] == 16'h0000)
      else $error("count upper half not zero");

   a_count_write_open: assert property (
      (access && q.pready && pwrite && !q.pslverr && paddr == `OFF_COUNT
       && !enabled && pstrb[1:0] == 2'b11)
      |=> q.count == $past(pwdata[15:0]))
      else $error("count write dropped while disabled");

   a_prog_capture: assert property (
      (access && q.pready && pwrite && !q.pslverr && paddr == `OFF_COUNT
       && !enabled && pstrb[1:0] == 2'b11)
      |=> q.prog == $past(pwdata[15:0]))
      else $error("programmed count not captured");

   a_prog_kept: assert property (
      !(access && q.pready && pwrite && paddr == `OFF_COUNT)
      |=> $stable(q.prog))
      else $error("programmed count changed without a write");

   a_count_stable: assert property (
      (!xfer_done && !(access && q.pready && pwrite && paddr == `OFF_COUNT))
      |=> $stable(q.count))
      else $error("count changed without a transfer or write");

   a_periph_addr_write: assert property (
      (access && q.pready && pwrite && !q.pslverr && paddr == `OFF_PERIPH
       && pstrb == 4'hf)
      |=> q.paddr == $past(pwdata))
      else $error("peripheral address write lost");

   a_mem_addr_write: assert property (
      (access && q.pready && pwrite && !q.pslverr && paddr == `OFF_MEMORY
       && pstrb == 4'hf)
      |=> q.maddr == $past(pwdata))
      else $error("memory address write lost");

   a_disabled_no_push: assert property (
      (!enabled && !q.skid_valid && !(q.out_valid && !xfer_ready))
      |=> !xfer_valid)
      else $error("descriptor issued while disabled");

endmodule

// ---- verification/xfer_engine_model.sv ----
// Purpose: Transfer engine standing behind the descriptor port
// Assumes: go and stall are driven by the bench
// Notes: One finish pulse per accepted descriptor
`timescale 1ns/1ps

module xfer_engine_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic go,
   input wire logic stall,
   input wire logic xfer_valid,
   output logic xfer_ready,
   output logic xfer_done
);
   assign xfer_ready = go & ~stall;
   // Finish one cycle after accept
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= xfer_valid & xfer_ready;
      end
   end
endmodule

// ---- verification/tb_dma_channel_count_address.sv ----
// Purpose: Self-checking bench of the channel 3 count and address part
// Assumes: APB answer waited for under a bound
// Notes: Count expectation kept by a behavioural model
`timescale 1ns/1ps
`include "dma_ch3_params.svh"

module tb_dma_channel_count_address;
   logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, go, stall;
   logic xfer_valid, xfer_ready, xfer_done, er;
   logic [7:0] paddr;
   logic [3:0] pstrb;
   logic [31:0] pwdata, prdata, s, rd, ep, em, t;
   logic [15:0] remaining;
   logic [1:0] pw, mw;
   logic cyc;
   dma_ch3_pkg::xfer_type xfer_desc;
   int fail_count = 0, n_compared = 0, dones, accepts, exp_cnt, prog;

   dma_channel_count_address dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
      .xfer_desc(xfer_desc), .xfer_done(xfer_done), .remaining(remaining));
   xfer_engine_model eng (.mclk(mclk), .rst_b(rst_b), .go(go),
      .stall(stall), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
      .xfer_done(xfer_done));

   // ==========================================================
   // Helpers
   function logic [31:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function logic [31:0] msk(input logic [1:0] w);
      return w == 2'b01 ? 32'hffff_fffe : w == 2'b10 ? 32'hffff_fffc
         : 32'hffff_ffff;
   endfunction
   task automatic chk(input string nm, input logic [69:0] seen,
      input logic [69:0] ex);
      n_compared++;
      if (seen !== ex) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fail_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task run(input logic [1:0] p, input logic [1:0] m, input logic c,
      input int n, input int tgt);
      int k;
      ep = rnd();
      em = rnd();
      t = rnd();
      // Reserved width code behaves as byte
      pw = (p == 2'b11) ? 2'b00 : p;
      mw = (m == 2'b11) ? 2'b00 : m;
      cyc = c;
      apb(1'b1, `OFF_PERIPH, ep);
      apb(1'b1, `OFF_MEMORY, em);
      apb(1'b1, `OFF_COUNT, {t[31:16], 16'(n)});
      exp_cnt = n;
      prog = n;
      dones = 0;
      accepts = 0;
      apb(1'b1, `OFF_CONFIG, 32'({m, p, 2'b00, c, 5'h01}));
      go <= 1'b1;
      k = 0;
      while ((dones < tgt || k < 4) && k < 200) begin
         @(posedge mclk);
         k++;
      end
      go <= 1'b0;
      chk("done count", 70'(dones >= tgt), 70'h1);
      repeat (8) @(posedge mclk);
      apb(1'b0, `OFF_COUNT, 32'h0);
      chk("count", 70'(rd), 70'(exp_cnt));
      chk("count err", 70'(er), 70'h0);
      chk("remaining", 70'(remaining), 70'(exp_cnt));
      apb(1'b1, `OFF_COUNT, 32'h9);
      apb(1'b0, `OFF_COUNT, 32'h0);
      chk("locked count", 70'(rd), 70'(exp_cnt));
      apb(1'b1, `OFF_CONFIG, 32'h0);
      apb(1'b0, `OFF_PERIPH, 32'h0);
      chk("periph addr", 70'(rd), 70'(ep));
      apb(1'b0, `OFF_MEMORY, 32'h0);
      chk("mem addr", 70'(rd), 70'(em));
   endtask

   // ==========================================================
   // Clock, stall pattern, model of the count
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      stall <= rnd() > 32'h9000_0000;
      if (xfer_valid && xfer_ready) begin
         accepts++;
         chk("desc", 70'(xfer_desc),
            70'({ep & msk(pw), em & msk(mw), pw, mw}));
      end
      if (xfer_done && exp_cnt != 0) begin
         dones++;
         exp_cnt--;
         if (exp_cnt == 0 && cyc) exp_cnt = prog;
      end
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      conclude();
   end

   // ==========================================================
   // Tests
   initial begin
      s = 32'd27719;
      {rst_b, psel, penable, pwrite, go, cyc} = '0;
      {paddr, pwdata, pw, mw, ep, em} = '0;
      pstrb = 4'hf;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 8'(`OFF_COUNT + 4 * i), 32'h0);
         chk("reset value", 70'(rd), 70'h0);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", 70'(er), 70'h1);
      chk("unmapped data", 70'(rd), 70'h0);
      apb(1'b1, `OFF_COUNT, 32'hffff_0003);
      apb(1'b0, `OFF_COUNT, 32'h0);
      chk("count field", 70'(rd), 70'h3);
      $display("registers done");
      for (int i = 0; i < 9; i++) begin
         run(2'(i / 3), 2'(i % 3), 1'b0, 2 + i % 2, 2 + i % 2);
      end
      run(2'b11, 2'b11, 1'b0, 2, 2);
      $display("widths done");
      run(2'b01, 2'b10, 1'b0, 0, 0);
      chk("zero count accepts", 70'(accepts), 70'h0);
      $display("zero count done");
      run(2'b10, 2'b01, 1'b1, 3, 4);
      $display("cyclic done");
      conclude();
   end
endmodule
